// ===== rtl/tpa_pkg.sv
package tpa_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_PIN_VALUES = 8'h34;
	localparam logic [7:0] OFS_PROBE_VIEW = 8'h35;
	localparam logic [7:0] OFS_SELFCHECK = 8'h36;
	localparam logic [7:0] OFS_REVISION = 8'h37;
	localparam logic [7:0] OFS_AUX_SELECT = 8'h38;
	localparam logic [7:0] OFS_PORT_ENABLE = 8'h33;
	localparam logic [7:0] OFS_BIT_SELECT = 8'h31;

	// ==========================================================
	// Reset values and field positions
	localparam logic [7:0] RST_PIN_VALUES = 8'h00;
	localparam logic [7:0] RST_SELFCHECK = 8'h40;
	localparam logic [7:0] RST_AUX_SELECT = 8'h00;
	localparam logic [7:0] RST_PORT_ENABLE = 8'h80;
	localparam logic [7:0] RST_BIT_SELECT = 8'h00;
	localparam int IO_ENABLE_BIT = 7;
	localparam int NONLINEAR_BIT = 6;
	localparam logic [7:0] PIN_FIELD_MASK = 8'h7E;
	localparam logic [7:0] SELFCHECK_MASK = 8'h4F;
	localparam logic [7:0] BIT_SELECT_MASK = 8'h07;
	localparam logic [7:0] PORT_ENABLE_MASK = 8'hFE;
	localparam logic [3:0] SELFTEST_ENABLE = 4'h9;
	localparam logic [3:0] SELFTEST_OFF = 4'h0;

	// Arbitrary neutral revision code.
	localparam logic [7:0] REVISION_DEFAULT = 8'h5A;

	// ==========================================================
	// Auxiliary pin source codes
	typedef enum logic [3:0] {
		TPA_SRC_TRISTATE = 4'h0,
		TPA_SRC_CONVERTER = 4'h1,
		TPA_SRC_CORRELATOR = 4'h2,
		TPA_SRC_MIN_LEVEL = 4'h4,
		TPA_SRC_ADC_I = 4'h5,
		TPA_SRC_ADC_Q = 4'h6,
		TPA_SRC_HIGH = 4'hA,
		TPA_SRC_LOW = 4'hB,
		TPA_SRC_TX_ACTIVE = 4'hC,
		TPA_SRC_RX_ACTIVE = 4'hD,
		TPA_SRC_SUBCARRIER = 4'hE,
		TPA_SRC_PROBE_BIT = 4'hF
	} tpa_src_e;

endpackage

// ===== rtl/tpa_aux_mux.sv
`timescale 1ns/1ps
// ==========================================================
// One auxiliary pin source selector.
module tpa_aux_mux (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] source_in,
	input wire logic converter_in,
	input wire logic correlator_in,
	input wire logic min_level_in,
	input wire logic adc_i_in,
	input wire logic adc_q_in,
	input wire logic transmit_active_in,
	input wire logic receive_active_in,
	input wire logic subcarrier_in,
	input wire logic slow_rate_in,
	input wire logic probe_bit_in,
	output logic aux_out,
	output logic aux_oe_out
);
	logic sel_level;
	logic sel_drive;

	// Reserved codes leave the pin undriven, like tristate.
	always_comb begin
		sel_level = 1'h0;
		sel_drive = 1'h1;
		unique case (source_in)
			tpa_pkg::TPA_SRC_CONVERTER: sel_level = converter_in;
			tpa_pkg::TPA_SRC_CORRELATOR: sel_level = correlator_in;
			tpa_pkg::TPA_SRC_MIN_LEVEL: sel_level = min_level_in;
			tpa_pkg::TPA_SRC_ADC_I: sel_level = adc_i_in;
			tpa_pkg::TPA_SRC_ADC_Q: sel_level = adc_q_in;
			tpa_pkg::TPA_SRC_HIGH: sel_level = 1'h1;
			tpa_pkg::TPA_SRC_LOW: sel_level = 1'h0;
			tpa_pkg::TPA_SRC_TX_ACTIVE: sel_level = transmit_active_in;
			tpa_pkg::TPA_SRC_RX_ACTIVE: sel_level = receive_active_in;
			// Subcarrier detection has no meaning at the slowest rate.
			tpa_pkg::TPA_SRC_SUBCARRIER:
				sel_level = subcarrier_in & ~slow_rate_in;
			tpa_pkg::TPA_SRC_PROBE_BIT: sel_level = probe_bit_in;
			default: sel_drive = 1'h0;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			aux_out <= 1'h0;
			aux_oe_out <= 1'h0;
		end else begin
			aux_out <= sel_level;
			aux_oe_out <= sel_drive;
		end
	end
endmodule

// ===== rtl/tpa_sync.sv
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser for a bus of pin levels.
module tpa_sync #(
	parameter int WIDTH = 6
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			stage_reg <= '0;
			sync_out <= '0;
		end else begin
			stage_reg <= async_in;
			sync_out <= stage_reg;
		end
	end
endmodule

// ===== rtl/tpa_test_port.sv
`timescale 1ns/1ps
// Functional notes
// - Pin value bit 7, with serial host, turns test port into GPIO.
// - Per-pin enable bits choose input or output.
// - Enabled pins drive stored values; bit 0 reserved.
// - Read returns live pins when I/O enabled.
// - Probe bus view readable at 35h.
// - Bit 6 selects nonlinear receive processing.
// - Self test runs only when enabled by 1001b.
// - Fixed revision code readable at 37h.
// - Shared code table: tristate, sources, high, low.
// - Code 1100 outputs transmit activity.
// - Code 1101 outputs receive activity.
// - Code 1110 outputs subcarrier detect, low at slowest rate.
// - Code 1111 outputs selected probe bus bit.
// - Three-bit field selects the probe bus bit.
// - Enable bits 6..1 drive matching test pins.
module tpa_test_port #(
	parameter logic [7:0] REVISION = tpa_pkg::REVISION_DEFAULT
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_hit_out,
	input wire logic serial_host_in,
	input wire logic [6:1] port_pin_in,
	output logic [6:1] port_pin_out,
	output logic [6:1] port_pin_oe_out,
	input wire logic [7:0] probe_bus_in,
	input wire logic selftest_cmd_in,
	output logic selftest_start_out,
	output logic nonlinear_receive_out,
	input wire logic [1:0] converter_in,
	input wire logic correlator_in,
	input wire logic min_level_in,
	input wire logic adc_i_in,
	input wire logic adc_q_in,
	input wire logic transmit_active_in,
	input wire logic receive_active_in,
	input wire logic subcarrier_in,
	input wire logic slow_rate_in,
	output logic aux_pin_one_out,
	output logic aux_pin_one_oe_out,
	output logic aux_pin_two_out,
	output logic aux_pin_two_oe_out
);
	// ==========================================================
	// Register storage
	logic [7:0] pin_values_reg;
	logic [7:0] selfcheck_reg;
	logic [7:0] aux_select_reg;
	logic [7:0] port_enable_reg;
	logic [7:0] bit_select_reg;

	// ==========================================================
	// Address decode
	wire hit_pin = reg_addr_in == tpa_pkg::OFS_PIN_VALUES;
	wire hit_probe = reg_addr_in == tpa_pkg::OFS_PROBE_VIEW;
	wire hit_self = reg_addr_in == tpa_pkg::OFS_SELFCHECK;
	wire hit_rev = reg_addr_in == tpa_pkg::OFS_REVISION;
	wire hit_aux = reg_addr_in == tpa_pkg::OFS_AUX_SELECT;
	wire hit_en = reg_addr_in == tpa_pkg::OFS_PORT_ENABLE;
	wire hit_bit = reg_addr_in == tpa_pkg::OFS_BIT_SELECT;
	wire any_hit = hit_pin | hit_probe | hit_self | hit_rev | hit_aux |
		hit_en | hit_bit;

	// Reserved positions are masked on write so they stay zero.
	wire [7:0] pin_values_next =
		reg_wdata_in & (tpa_pkg::PIN_FIELD_MASK | 8'h80);
	wire [7:0] selfcheck_next = reg_wdata_in & tpa_pkg::SELFCHECK_MASK;
	wire [7:0] port_enable_next = reg_wdata_in & tpa_pkg::PORT_ENABLE_MASK;
	wire [7:0] bit_select_next = reg_wdata_in & tpa_pkg::BIT_SELECT_MASK;
	// Both nibbles of the aux select register are stored unmasked; reserved codes are kept and leave the pin undriven.
	wire [7:0] aux_select_next = reg_wdata_in;

	// ==========================================================
	// Write strobes
	// Read-only and unmapped offsets have no strobe, so writes to them
	// are dropped without a trace.
	wire wr_pin = reg_wr_in & hit_pin;
	wire wr_self = reg_wr_in & hit_self;
	wire wr_aux = reg_wr_in & hit_aux;
	wire wr_en = reg_wr_in & hit_en;
	wire wr_bit = reg_wr_in & hit_bit;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pin_values_reg <= tpa_pkg::RST_PIN_VALUES;
		end else if (wr_pin) begin
			pin_values_reg <= pin_values_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			selfcheck_reg <= tpa_pkg::RST_SELFCHECK;
		end else if (wr_self) begin
			selfcheck_reg <= selfcheck_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			aux_select_reg <= tpa_pkg::RST_AUX_SELECT;
		end else if (wr_aux) begin
			aux_select_reg <= aux_select_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			port_enable_reg <= tpa_pkg::RST_PORT_ENABLE;
		end else if (wr_en) begin
			port_enable_reg <= port_enable_next;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			bit_select_reg <= tpa_pkg::RST_BIT_SELECT;
		end else if (wr_bit) begin
			bit_select_reg <= bit_select_next;
		end
	end

	// ==========================================================
	// Test port pins
	logic [6:1] pin_live;

	tpa_sync #(
		.WIDTH(6)
	) u_pin_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(port_pin_in),
		.sync_out(pin_live)
	);

	wire io_mode = pin_values_reg[tpa_pkg::IO_ENABLE_BIT] &
		serial_host_in;

	// ==========================================================
	// Per-pin drive and enable
	logic [6:1] pin_drive_next;
	logic [6:1] pin_oe_next;

	// Each driver follows its own enable bit, only in I/O mode.
	for (genvar p = 1; p <= 6; p++) begin : g_pin
		assign pin_drive_next[p] = pin_values_reg[p];
		assign pin_oe_next[p] = io_mode & port_enable_reg[p];
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			port_pin_out <= '0;
			port_pin_oe_out <= '0;
		end else begin
			port_pin_out <= pin_drive_next;
			port_pin_oe_out <= pin_oe_next;
		end
	end

	// ==========================================================
	// Receiver option and self test
	assign nonlinear_receive_out =
		selfcheck_reg[tpa_pkg::NONLINEAR_BIT];

	wire selftest_armed =
		selfcheck_reg[3:0] == tpa_pkg::SELFTEST_ENABLE;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			selftest_start_out <= 1'h0;
		end else begin
			selftest_start_out <= selftest_armed & selftest_cmd_in;
		end
	end

	// ==========================================================
	// Auxiliary pins
	wire probe_bit = probe_bus_in[bit_select_reg[2:0]];

	tpa_aux_mux u_aux_one (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.source_in(aux_select_reg[7:4]),
		.converter_in(converter_in[0]),
		.correlator_in(correlator_in),
		.min_level_in(min_level_in),
		.adc_i_in(adc_i_in),
		.adc_q_in(adc_q_in),
		.transmit_active_in(transmit_active_in),
		.receive_active_in(receive_active_in),
		.subcarrier_in(subcarrier_in),
		.slow_rate_in(slow_rate_in),
		.probe_bit_in(probe_bit),
		.aux_out(aux_pin_one_out),
		.aux_oe_out(aux_pin_one_oe_out)
	);

	tpa_aux_mux u_aux_two (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.source_in(aux_select_reg[3:0]),
		.converter_in(converter_in[1]),
		.correlator_in(correlator_in),
		.min_level_in(min_level_in),
		.adc_i_in(adc_i_in),
		.adc_q_in(adc_q_in),
		.transmit_active_in(transmit_active_in),
		.receive_active_in(receive_active_in),
		.subcarrier_in(subcarrier_in),
		.slow_rate_in(slow_rate_in),
		.probe_bit_in(probe_bit),
		.aux_out(aux_pin_two_out),
		.aux_oe_out(aux_pin_two_oe_out)
	);

	// ==========================================================
	// Read path
	// In I/O mode the pin bits show the synchronised live levels.
	wire [7:0] pin_readback = io_mode ?
		{pin_values_reg[7], pin_live, 1'h0} : pin_values_reg;

	// Each register offers its value only while addressed, so the read
	// data is a plain OR of the terms below.
	wire [7:0] rd_pin = hit_pin ? pin_readback : 8'h00;
	wire [7:0] rd_probe = hit_probe ? probe_bus_in : 8'h00;
	wire [7:0] rd_self = hit_self ? selfcheck_reg : 8'h00;
	wire [7:0] rd_rev = hit_rev ? REVISION : 8'h00;
	wire [7:0] rd_aux = hit_aux ? aux_select_reg : 8'h00;
	wire [7:0] rd_en = hit_en ? port_enable_reg : 8'h00;
	wire [7:0] rd_bit = hit_bit ? bit_select_reg : 8'h00;

	// Unmapped addresses leave every term at zero.
	wire [7:0] rdata_sel = rd_pin | rd_probe | rd_self | rd_rev |
		rd_aux | rd_en | rd_bit;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_sel;
		end
	end

	// The hit flag is taken with the data, so both describe one read.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reg_hit_out <= 1'h0;
		end else if (reg_rd_in) begin
			reg_hit_out <= any_hit;
		end
	end
endmodule

// ===== dv/tpa_test_port_assertions.sv
`timescale 1ns/1ps
module tpa_test_port_checker #(
	parameter logic [7:0] REVISION = tpa_pkg::REVISION_DEFAULT
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_hit_out,
	input wire logic serial_host_in,
	input wire logic [6:1] port_pin_oe_out,
	input wire logic [7:0] probe_bus_in,
	input wire logic selftest_cmd_in,
	input wire logic selftest_start_out,
	input wire logic nonlinear_receive_out,
	input wire logic receive_active_in,
	input wire logic aux_pin_one_out,
	input wire logic aux_pin_one_oe_out,
	input wire logic aux_pin_two_out,
	input wire logic aux_pin_two_oe_out
);
	// Shadow of the auxiliary select register.
	logic [7:0] aux_sh;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in)
			aux_sh <= 8'h00;
		else if (reg_wr_in && reg_addr_in == 8'h38)
			aux_sh <= reg_wdata_in;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_rd(a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	a_revision_read: assert property (
		s_rd(8'h37) |=> reg_rdata_out == REVISION)
		else $error("revision read wrong");
	a_probe_view: assert property (
		s_rd(8'h35) |=> reg_rdata_out == $past(probe_bus_in))
		else $error("probe view wrong");
	a_value_reserved: assert property (
		s_rd(8'h34) |=> !reg_rdata_out[0])
		else $error("reserved bit set");
	a_unmapped_read: assert property (
		reg_rd_in && !(reg_addr_in inside {8'h31, [8'h33:8'h38]})
		|=> reg_rdata_out == 8'h00 && !reg_hit_out)
		else $error("unmapped read wrong");
	a_pin_io_gate: assert property (
		!serial_host_in |=> port_pin_oe_out == 6'h00)
		else $error("pins driven without host");
	a_selftest_pulse: assert property (
		selftest_start_out |-> $past(selftest_cmd_in))
		else $error("self test start without command");
	a_nonlinear_bit: assert property (
		reg_wr_in && reg_addr_in == 8'h36
		|=> nonlinear_receive_out == $past(reg_wdata_in[6]))
		else $error("nonlinear bit wrong");
	a_aux_tristate: assert property (
		aux_sh[7:4] == 4'h0 |=> !aux_pin_one_oe_out)
		else $error("aux one not tristate");
	a_aux_high: assert property (
		aux_sh[7:4] == 4'hA |=> aux_pin_one_out && aux_pin_one_oe_out)
		else $error("aux one not high");
	a_aux_rx_active: assert property (
		aux_sh[3:0] == 4'hD |=> aux_pin_two_oe_out
		&& aux_pin_two_out == $past(receive_active_in))
		else $error("aux two receive activity wrong");
endmodule
bind tpa_test_port tpa_test_port_checker #(.REVISION(REVISION)) i_chk (
	.mclk_in, .rst_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
	.reg_wdata_in, .reg_rdata_out, .reg_hit_out, .serial_host_in,
	.port_pin_oe_out, .probe_bus_in, .selftest_cmd_in,
	.selftest_start_out, .nonlinear_receive_out, .receive_active_in,
	.aux_pin_one_out, .aux_pin_one_oe_out, .aux_pin_two_out,
	.aux_pin_two_oe_out);

// ===== dv/tpa_pin_model.sv
`timescale 1ns/1ps
// Board side of the test port: undriven pins show external levels.
module tpa_pin_model (
	input wire logic [6:1] drive_in,
	input wire logic [6:1] oe_in,
	input wire logic [6:1] ext_in,
	output logic [6:1] pin_out
);
	assign pin_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule

// ===== dv/tpa_test_port_bench.sv
`timescale 1ns/1ps
module tpa_test_port_bench;
	localparam logic [15:0] OE_TAB = 16'hFC76;
	localparam logic [15:0] V1 = 16'h6424;
	localparam logic [15:0] V2 = 16'h6426;
	localparam logic [15:0] FLIP = 16'hF076;
	localparam logic [7:0] REV = tpa_pkg::REVISION_DEFAULT;
	logic mclk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic reg_wr_in = 1'h0;
	logic reg_rd_in = 1'h0;
	logic serial_host_in = 1'h0;
	logic selftest_cmd_in = 1'h0;
	logic slow_rate_in = 1'h0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] probe_bus_in = 8'hA5;
	logic [8:0] src = 9'h196;
	logic [6:1] ext = 6'h05;
	logic [6:1] pin_in, pin_out, pin_oe;
	logic [7:0] reg_rdata_out;
	logic hit, st_out, nl_out, a1, a1_oe, a2, a2_oe;
	int bad_count = 0;
	int n_compared = 0;
	tpa_test_port i_dut (.mclk_in, .rst_n_in, .reg_wr_in, .reg_rd_in,
		.reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_hit_out(hit),
		.serial_host_in, .port_pin_in(pin_in), .port_pin_out(pin_out),
		.port_pin_oe_out(pin_oe), .probe_bus_in, .selftest_cmd_in,
		.selftest_start_out(st_out), .nonlinear_receive_out(nl_out),
		.converter_in(src[1:0]), .correlator_in(src[2]),
		.min_level_in(src[3]), .adc_i_in(src[4]), .adc_q_in(src[5]),
		.transmit_active_in(src[6]), .receive_active_in(src[7]),
		.subcarrier_in(src[8]), .slow_rate_in, .aux_pin_one_out(a1),
		.aux_pin_one_oe_out(a1_oe), .aux_pin_two_out(a2),
		.aux_pin_two_oe_out(a2_oe));
	tpa_pin_model i_pins (.drive_in(pin_out), .oe_in(pin_oe),
		.ext_in(ext), .pin_out(pin_in));
	initial forever #25 mclk_in = ~mclk_in;
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge mclk_in);
		reg_wr_in = 1'h1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(negedge mclk_in);
		reg_wr_in = 1'h0;
	endtask
	task automatic rd(logic [7:0] a, e, m, logic h);
		@(negedge mclk_in);
		reg_rd_in = 1'h1;
		reg_addr_in = a;
		@(negedge mclk_in);
		reg_rd_in = 1'h0;
		chk($sformatf("reg %h", a), e, reg_rdata_out & m);
		chk("hit", {7'h00, h}, {7'h00, hit});
	endtask
	task automatic pulse(logic e);
		@(negedge mclk_in);
		selftest_cmd_in = 1'h1;
		@(negedge mclk_in);
		selftest_cmd_in = 1'h0;
		chk("start", {7'h00, e}, {7'h00, st_out});
		@(negedge mclk_in);
		chk("start", 8'h00, {7'h00, st_out});
	endtask
	initial begin
		repeat (3000) @(posedge mclk_in);
		bad_count++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		@(negedge mclk_in);
		rst_n_in = 1'h1;
		chk("nonlinear", 8'h01, {7'h00, nl_out});
		rd(8'h34, 8'h00, 8'hFF, 1'h1);
		rd(8'h36, 8'h40, 8'hFF, 1'h1);
		rd(8'h38, 8'h00, 8'hFF, 1'h1);
		rd(8'h3C, 8'h00, 8'hFF, 1'h0);
		wr(8'h37, 8'hFF);
		rd(8'h37, REV, 8'hFF, 1'h1);
		rd(8'h35, 8'hA5, 8'hFF, 1'h1);
		wr(8'h36, 8'hB9);
		rd(8'h36, 8'h09, 8'hFF, 1'h1);
		chk("nonlinear", 8'h00, {7'h00, nl_out});
		pulse(1'h1);
		wr(8'h36, 8'h40);
		pulse(1'h0);
		serial_host_in = 1'h1;
		wr(8'h33, 8'hF1);
		wr(8'h34, 8'hD7);
		repeat (3) @(negedge mclk_in);
		chk("oe", 8'h38, {2'h0, pin_oe});
		chk("drive", 8'h28, {2'h0, pin_out & pin_oe});
		rd(8'h34, 8'h5A, 8'h7E, 1'h1);
		rd(8'h33, 8'hF0, 8'hFF, 1'h1);
		serial_host_in = 1'h0;
		repeat (2) @(negedge mclk_in);
		chk("oe", 8'h00, {2'h0, pin_oe});
		serial_host_in = 1'h1;
		wr(8'h34, 8'h57);
		repeat (2) @(negedge mclk_in);
		chk("oe", 8'h00, {2'h0, pin_oe});
		rd(8'h34, 8'h56, 8'hFF, 1'h1);
		wr(8'h31, 8'h01);
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 16; c++) begin
				wr(8'h38, {c[3:0], c[3:0]});
				repeat (2) @(negedge mclk_in);
				chk("aux_pin_one", {6'h00, OE_TAB[c], V1[c] ^ (p[0] & FLIP[c])},
					{6'h00, a1_oe, a1 & a1_oe});
				chk("aux_pin_two", {6'h00, OE_TAB[c], V2[c] ^ (p[0] & FLIP[c])},
					{6'h00, a2_oe, a2 & a2_oe});
			end
			src = ~src;
			probe_bus_in = ~probe_bus_in;
		end
		rd(8'h38, 8'hFF, 8'hFF, 1'h1);
		slow_rate_in = 1'h1;
		wr(8'h38, 8'hEE);
		repeat (2) @(negedge mclk_in);
		chk("aux_pin_one sub", 8'h00, {7'h00, a1 & a1_oe});
		close_out();
	end
endmodule
